// [rpd_consts.svh]
`ifndef RPD_CONSTS_SVH
`define RPD_CONSTS_SVH
// Notes on behaviour
// - burst mode: first reading above threshold starts a 128-reading capture, level ignored.
// - the largest of the 128 captured readings is the burst result.
// - burst mode keeps the latest triggered burst result while no burst arrives.
// - continuous mode reports the peak of each 128 consecutive readings, no trigger.
// - continuous mode is selected after reset until burst mode is written.
// - output disabled forces the reported power to -99.00 dBm.
// - automatic shut-off mute forces the reported power to -96.00 dBm unless output is disabled.

// widths
`define RPD_SAMPLE_W 16
`define RPD_CNT_W 8
`define RPD_FREQ_W 16
`define RPD_ADDR_W 8
`define RPD_DATA_W 32
`define RPD_HELP_W 9

// capture window length in readings
`define RPD_WINDOW_LEN 128

// register byte addresses
`define RPD_ADDR_CTRL 8'h00
`define RPD_ADDR_THRESH 8'h04
`define RPD_ADDR_FREQ 8'h08
`define RPD_ADDR_POWER 8'h0C
`define RPD_ADDR_STATUS 8'h10

// field positions
`define RPD_CTRL_BURST 0
`define RPD_CTRL_DISABLE 1
`define RPD_STAT_BUSY 0
`define RPD_STAT_SEEN 1
`define RPD_STAT_MUTE 2
`define RPD_STAT_DISABLE 3
`define RPD_POWER_SEEN 16

// forced values, hundredths of a dBm, two's complement
`define RPD_PWR_DISABLED 16'hD954
`define RPD_PWR_MUTED 16'hDA80

// reset values
`define RPD_RST_THRESH 16'h0000
`define RPD_RST_FREQ 16'h0000
`define RPD_RST_PWR 16'h0000
`endif

// [rpd_detector_model.sv]
module rpd_detector_model (
    input wire logic clk_sys, // system clock
    output logic sampleValid, // reading strobe
    output rpd_pkg::rpd_sample_t sampleData // corrected reading
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle line carries a pattern, never a stale reading
    initial begin
        sampleValid = 1'b0;
        sampleData = 16'h5A5A;
    end

    // one reading, called just after an edge; hold keeps the strobe for the next one
    task automatic put(input rpd_pkg::rpd_sample_t v, input bit hold);
        sampleValid <= 1'b1;
        sampleData <= v;
        @(posedge clk_sys);
        if (!hold) begin
            sampleValid <= 1'b0;
            sampleData <= ~v;
        end
    endtask
endmodule // rpd_detector_model

// [rpd_peak_window.sv]
`include "rpd_consts.svh"
module rpd_peak_window #(
    parameter int WINDOW_LEN = `RPD_WINDOW_LEN
) (
    input wire logic clk_sys, // system clock
    input wire logic nrst, // async reset, active low
    input wire logic ce, // clock enable
    input wire logic clear, // abort any capture
    input wire logic first, // a capture may start on this reading
    input wire logic sampleValid, // reading strobe
    input wire rpd_pkg::rpd_sample_t sampleData, // detector reading
    output logic busy, // capture in progress
    output logic done, // window complete pulse
    output rpd_pkg::rpd_sample_t peakMax // largest reading of window
);
    localparam logic [`RPD_CNT_W-1:0] LAST = `RPD_CNT_W'(WINDOW_LEN - 1);
    localparam rpd_pkg::rpd_peak_s RST = '{rpd_pkg::PH_IDLE, '0, '0, 1'b0};

    rpd_pkg::rpd_peak_s st_r;
    rpd_pkg::rpd_peak_s st_nxt;

    // window sequencing and running maximum
    always_comb begin
        st_nxt = st_r;
        st_nxt.done = 1'b0;
        if (clear) begin
            st_nxt.phase = rpd_pkg::PH_IDLE;
            st_nxt.count = '0;
        end else if (sampleValid) begin
            case (st_r.phase)
                rpd_pkg::PH_IDLE: begin
                    if (first) begin
                        st_nxt.phase = rpd_pkg::PH_CAPT;
                        st_nxt.count = `RPD_CNT_W'(1);
                        st_nxt.peak = sampleData;
                    end
                end
                rpd_pkg::PH_CAPT: begin
                    if (sampleData > st_r.peak) begin
                        st_nxt.peak = sampleData;
                    end
                    if (st_r.count == LAST) begin
                        st_nxt.phase = rpd_pkg::PH_IDLE;
                        st_nxt.count = '0;
                        st_nxt.done = 1'b1;
                    end else begin
                        st_nxt.count = st_r.count + `RPD_CNT_W'(1);
                    end
                end
                default: begin
                    st_nxt.phase = rpd_pkg::PH_IDLE;
                end
            endcase
        end
    end

    // state register
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            st_r <= RST;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    assign busy = (st_r.phase == rpd_pkg::PH_CAPT);
    assign done = st_r.done;
    assign peakMax = st_r.peak;

    default clocking pcb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    // checks on capture start and running maximum
    capture_start_a: assert property (
        !busy && sampleValid && first && !clear && ce
        |=> busy && peakMax == $past(sampleData))
        else $error("capture did not start on trigger reading");
    running_max_a: assert property (
        busy && sampleValid && !clear && ce |=> peakMax >= $past(sampleData))
        else $error("peak below a captured reading");
endmodule // rpd_peak_window

// [rpd_pkg.sv]
`include "rpd_consts.svh"
package rpd_pkg;
    typedef logic signed [`RPD_SAMPLE_W-1:0] rpd_sample_t;

    // capture phases of the peak window
    typedef enum logic {
        PH_IDLE,
        PH_CAPT
    } rpd_phase_e;

    // peak window state
    typedef struct packed {
        rpd_phase_e phase;
        logic [`RPD_CNT_W-1:0] count;
        rpd_sample_t peak;
        logic done;
    } rpd_peak_s;

    // report block state
    typedef struct packed {
        logic burstMode;
        logic txDisable;
        rpd_sample_t thresh;
        logic [`RPD_FREQ_W-1:0] freq;
        rpd_sample_t measured;
        rpd_sample_t power;
        logic reportNew;
        logic burstSeen;
        logic [`RPD_DATA_W-1:0] rdData;
    } rpd_regs_s;
endpackage

// [rpd_power_report.sv]
// Our own choices: the register offsets and the plain strobed port.
`include "rpd_consts.svh"
module rpd_power_report #(
    parameter int WINDOW_LEN = `RPD_WINDOW_LEN
) (
    input wire logic clk_sys, // system clock
    input wire logic nrst, // async reset, active low
    input wire logic ce, // clock enable
    input wire logic [`RPD_ADDR_W-1:0] regAddr, // register byte address
    input wire logic [`RPD_DATA_W-1:0] regWrData, // write data
    input wire logic regWrite, // write strobe
    input wire logic regRead, // read strobe
    output logic [`RPD_DATA_W-1:0] regRdData, // read data, cycle after strobe
    input wire logic sampleValid, // reading strobe
    input wire rpd_pkg::rpd_sample_t sampleData, // corrected reading
    input wire logic autoMute, // automatic shut-off active
    output rpd_pkg::rpd_sample_t reportPower, // reported power
    output logic reportNew, // report updated pulse
    output logic [`RPD_FREQ_W-1:0] calFreq // frequency to calibration
);
    localparam rpd_pkg::rpd_regs_s RST = '{
        1'b0,
        1'b0,
        `RPD_RST_THRESH,
        `RPD_RST_FREQ,
        `RPD_RST_PWR,
        `RPD_RST_PWR,
        1'b0,
        1'b0,
        '0
    };

    rpd_pkg::rpd_regs_s st_r;
    rpd_pkg::rpd_regs_s st_nxt;

    logic peakBusy;
    logic peakDone;
    rpd_pkg::rpd_sample_t peakMax;
    logic startOk;
    logic wrCtrl;
    logic modeChange;
    logic clearPeak;

    // register write decode
    assign wrCtrl = regWrite && (regAddr == `RPD_ADDR_CTRL);
    assign modeChange = wrCtrl && (regWrData[`RPD_CTRL_BURST] != st_r.burstMode);
    assign clearPeak = modeChange;

    // trigger: burst needs a reading above threshold, continuous does not
    always_comb begin
        if (st_r.burstMode) begin
            startOk = (sampleData > st_r.thresh);
        end else begin
            startOk = 1'b1;
        end
    end

    // capture window shared by both modes
    rpd_peak_window #(
        .WINDOW_LEN(WINDOW_LEN)
    ) u_peak (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .ce(ce),
        .clear(clearPeak),
        .first(startOk),
        .sampleValid(sampleValid),
        .sampleData(sampleData),
        .busy(peakBusy),
        .done(peakDone),
        .peakMax(peakMax)
    );

    // registers, measurement hold and forced report values
    always_comb begin
        st_nxt = st_r;
        st_nxt.reportNew = 1'b0;
        st_nxt.rdData = '0;
        if (regWrite) begin
            case (regAddr)
                `RPD_ADDR_CTRL: begin
                    st_nxt.burstMode = regWrData[`RPD_CTRL_BURST];
                    st_nxt.txDisable = regWrData[`RPD_CTRL_DISABLE];
                end
                `RPD_ADDR_THRESH: begin
                    st_nxt.thresh = regWrData[`RPD_SAMPLE_W-1:0];
                end
                `RPD_ADDR_FREQ: begin
                    st_nxt.freq = regWrData[`RPD_FREQ_W-1:0];
                end
                default: begin
                    st_nxt.freq = st_r.freq;
                end
            endcase
        end
        if (peakDone) begin
            st_nxt.measured = peakMax;
            st_nxt.reportNew = 1'b1;
            if (st_r.burstMode) begin
                st_nxt.burstSeen = 1'b1;
            end
        end
        if (st_nxt.txDisable) begin
            st_nxt.power = `RPD_PWR_DISABLED;
        end else if (autoMute) begin
            st_nxt.power = `RPD_PWR_MUTED;
        end else begin
            st_nxt.power = st_nxt.measured;
        end
        if (regRead) begin
            case (regAddr)
                `RPD_ADDR_CTRL: begin
                    st_nxt.rdData[`RPD_CTRL_BURST] = st_r.burstMode;
                    st_nxt.rdData[`RPD_CTRL_DISABLE] = st_r.txDisable;
                end
                `RPD_ADDR_THRESH: begin
                    st_nxt.rdData[`RPD_SAMPLE_W-1:0] = st_r.thresh;
                end
                `RPD_ADDR_FREQ: begin
                    st_nxt.rdData[`RPD_FREQ_W-1:0] = st_r.freq;
                end
                `RPD_ADDR_POWER: begin
                    st_nxt.rdData[`RPD_SAMPLE_W-1:0] = st_r.power;
                    st_nxt.rdData[`RPD_POWER_SEEN] = st_r.burstSeen;
                end
                `RPD_ADDR_STATUS: begin
                    st_nxt.rdData[`RPD_STAT_BUSY] = peakBusy;
                    st_nxt.rdData[`RPD_STAT_SEEN] = st_r.burstSeen;
                    st_nxt.rdData[`RPD_STAT_MUTE] = autoMute;
                    st_nxt.rdData[`RPD_STAT_DISABLE] = st_r.txDisable;
                end
                default: begin
                    st_nxt.rdData = '0;
                end
            endcase
        end
    end

    // state register
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            st_r <= RST;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from flops
    assign regRdData = st_r.rdData;
    assign reportPower = st_r.power;
    assign reportNew = st_r.reportNew;
    assign calFreq = st_r.freq;

    // helper: readings taken into the current window
    logic [`RPD_HELP_W-1:0] helpCnt;
    logic helpAcc;
    assign helpAcc = sampleValid && !clearPeak && (peakBusy || startOk);
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            helpCnt <= '0;
        end else if (ce) begin
            if (clearPeak) begin
                helpCnt <= '0;
            end else if (peakDone) begin
                helpCnt <= `RPD_HELP_W'(helpAcc);
            end else begin
                helpCnt <= helpCnt + `RPD_HELP_W'(helpAcc);
            end
        end
    end

    default clocking rcb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    // window length and trigger checks
    window_len_a: assert property (
        peakDone |-> helpCnt == `RPD_HELP_W'(WINDOW_LEN))
        else $error("window did not hold the full reading count");
    below_thresh_a: assert property (
        st_r.burstMode && !peakBusy && sampleValid && ce
        && !(sampleData > st_r.thresh) |=> !peakBusy)
        else $error("burst capture started below threshold");
    burst_hold_a: assert property (
        st_r.burstMode && !peakDone && ce && !regWrite
        |=> $stable(st_r.measured))
        else $error("burst result changed with no capture");
    cont_start_a: assert property (
        !st_r.burstMode && !peakBusy && sampleValid && ce && !regWrite
        |=> peakBusy)
        else $error("continuous window did not start");
    mode_reset_a: assert property (
        !st_r.burstMode && !(wrCtrl && regWrData[`RPD_CTRL_BURST]) && ce
        |=> !st_r.burstMode)
        else $error("left continuous mode without a write");
    disabled_pwr_a: assert property (
        st_r.txDisable && !regWrite && ce |=> reportPower == `RPD_PWR_DISABLED)
        else $error("disabled output not forced to -99.00 dBm");
    muted_pwr_a: assert property (
        !st_r.txDisable && !regWrite && autoMute && ce
        |=> reportPower == `RPD_PWR_MUTED)
        else $error("muted output not forced to -96.00 dBm");
    report_time_a: assert property (
        peakDone && ce |=> reportNew && st_r.measured == $past(peakMax))
        else $error("report did not follow window end by one cycle");
    freq_store_a: assert property (
        regWrite && regAddr == `RPD_ADDR_FREQ && ce
        |=> calFreq == $past(regWrData[`RPD_FREQ_W-1:0]))
        else $error("frequency not passed to calibration");

    // threshold storage, burst seen mark and register readback
    thresh_store_a: assert property (
        regWrite && regAddr == `RPD_ADDR_THRESH && ce
        |=> st_r.thresh == $past(regWrData[`RPD_SAMPLE_W-1:0]))
        else $error("burst threshold not stored");
    seen_set_a: assert property (
        st_r.burstMode && peakDone && ce |=> st_r.burstSeen)
        else $error("burst result not marked as seen");
    seen_kept_a: assert property (
        st_r.burstSeen && ce |=> st_r.burstSeen)
        else $error("burst seen mark lost");
    power_read_a: assert property (
        regRead && regAddr == `RPD_ADDR_POWER && ce
        |=> regRdData[`RPD_SAMPLE_W-1:0] == $past(st_r.power))
        else $error("power register read does not match report");
    cont_report_a: assert property (
        !st_r.burstMode && peakDone && !st_r.txDisable && !autoMute && !regWrite && ce
        |=> reportPower == $past(peakMax))
        else $error("continuous window peak not reported");
    status_read_a: assert property (
        regRead && regAddr == `RPD_ADDR_STATUS && ce
        |=> regRdData[`RPD_STAT_DISABLE] == $past(st_r.txDisable))
        else $error("status disable bit does not match control");

    // main scenarios
    burst_done_c: cover property (st_r.burstMode && peakDone);
    cont_done_c: cover property (!st_r.burstMode && peakDone);
    disabled_c: cover property (st_r.txDisable && reportNew);
    muted_c: cover property (autoMute && !st_r.txDisable && reportNew);
endmodule // rpd_power_report

// [rpd_power_report_bench.sv]
`include "rpd_consts.svh"
module rpd_power_report_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int WLEN = 4;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic [`RPD_ADDR_W-1:0] regAddr = 8'h00;
    logic [`RPD_DATA_W-1:0] regWrData = 32'h0;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic autoMute = 1'b0;
    logic ce = 1'b1;
    logic [`RPD_DATA_W-1:0] regRdData;
    logic sampleValid;
    logic reportNew;
    logic [`RPD_FREQ_W-1:0] calFreq;
    rpd_pkg::rpd_sample_t sampleData, reportPower, thr, held;
    rpd_pkg::rpd_sample_t win[WLEN];
    logic [31:0] rdv, f;
    int err_total = 0;
    int compares = 0;

    // 100 MHz clock
    always #5 clk_sys = ~clk_sys;

    rpd_power_report #(.WINDOW_LEN(WLEN)) i_dut (
        .clk_sys(clk_sys), .nrst(nrst), .ce(ce), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
        .regRdData(regRdData), .sampleValid(sampleValid), .sampleData(sampleData),
        .autoMute(autoMute), .reportPower(reportPower), .reportNew(reportNew),
        .calFreq(calFreq)
    );

    rpd_detector_model i_det (
        .clk_sys(clk_sys), .sampleValid(sampleValid), .sampleData(sampleData)
    );

    task automatic chk_val(input string what, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic chk_bit(input string what, input logic e, input logic g);
        compares++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %s expected %b seen %b", what, e, g);
        end
    endtask

    task automatic end_sim;
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // single-cycle bus write and read
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge clk_sys);
        regWrite <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk_sys);
        regRead <= 1'b0;
        #1 rdv = regRdData;
    endtask

    task automatic settle;
        repeat (2) @(posedge clk_sys);
        #1;
    endtask

    // largest reading of the window
    function automatic rpd_pkg::rpd_sample_t peak();
        rpd_pkg::rpd_sample_t m;
        m = win[0];
        for (int i = 1; i < WLEN; i++) begin
            if (win[i] > m) m = win[i];
        end
        return m;
    endfunction

    // send a back-to-back window, check the report one edge after the done pulse
    task automatic run_win(input logic expRep, input rpd_pkg::rpd_sample_t expPwr);
        @(posedge clk_sys);
        for (int i = 0; i < WLEN; i++) i_det.put(win[i], i < WLEN - 1);
        @(posedge clk_sys);
        #1;
        chk_bit("reportNew", expRep, reportNew);
        chk_val("reportPower", {16'h0, expPwr}, {16'h0, reportPower});
    endtask

    // watchdog against a hung run
    initial begin
        repeat (5000) @(posedge clk_sys);
        err_total++;
        $display("MISMATCH watchdog expected finish seen hang");
        end_sim();
    end

    initial begin
        void'($urandom(12265));
        repeat (4) @(posedge clk_sys);
        nrst <= 1'b1;
        #1;
        chk_val("reportPower", 32'h0, {16'h0, reportPower});
        chk_val("calFreq", 32'h0, {16'h0, calFreq});
        rd(`RPD_ADDR_CTRL);
        chk_val("ctrl", 32'h0, rdv);
        rd(8'h14);
        chk_val("unmapped", 32'h0, rdv);
        $display("test reset done");
        // continuous windows, corner values then random
        for (int k = 0; k < 6; k++) begin
            for (int i = 0; i < WLEN; i++) begin
                win[i] = (k == 0) ? 16'h8000 : 16'($urandom);
            end
            if (k == 1) win[WLEN-1] = 16'h7FFF;
            run_win(1'b1, peak());
        end
        rd(`RPD_ADDR_POWER);
        chk_val("power reg", {16'h0, peak()}, rdv);
        $display("test continuous done");
        // burst: nothing above threshold, then a triggered capture
        thr = 16'($urandom_range(1000, 0));
        wr(`RPD_ADDR_CTRL, 32'h1);
        wr(`RPD_ADDR_THRESH, {16'h0, thr});
        rd(`RPD_ADDR_THRESH);
        chk_val("thresh reg", {16'h0, thr}, rdv);
        held = peak();
        for (int i = 0; i < WLEN; i++) win[i] = thr - 16'(i);
        run_win(1'b0, held);
        win[0] = thr + 16'h0001;
        win[1] = thr - 16'h01F4;
        win[2] = thr + 16'h012C;
        win[3] = 16'hDCD8;
        held = thr + 16'h012C;
        run_win(1'b1, held);
        for (int i = 0; i < WLEN; i++) win[i] = thr - 16'h0100;
        run_win(1'b0, held);
        rd(`RPD_ADDR_POWER);
        chk_val("power reg", {15'h0, 1'b1, held}, rdv);
        $display("test burst done");
        // forced values: disable wins over mute
        wr(`RPD_ADDR_CTRL, 32'h3);
        settle();
        chk_val("disabled", {16'h0, `RPD_PWR_DISABLED}, {16'h0, reportPower});
        @(posedge clk_sys);
        autoMute <= 1'b1;
        settle();
        chk_val("disabled muted", {16'h0, `RPD_PWR_DISABLED}, {16'h0, reportPower});
        rd(`RPD_ADDR_STATUS);
        chk_val("status", (32'h1 << `RPD_STAT_SEEN) | (32'h1 << `RPD_STAT_MUTE)
            | (32'h1 << `RPD_STAT_DISABLE), rdv);
        wr(`RPD_ADDR_CTRL, 32'h1);
        settle();
        chk_val("muted", {16'h0, `RPD_PWR_MUTED}, {16'h0, reportPower});
        @(posedge clk_sys);
        autoMute <= 1'b0;
        settle();
        chk_val("released", {16'h0, held}, {16'h0, reportPower});
        $display("test forced done");
        // operating frequency handed to calibration
        for (int k = 0; k < 3; k++) begin
            f = $urandom;
            wr(`RPD_ADDR_FREQ, f);
            settle();
            chk_val("calFreq", {16'h0, f[15:0]}, {16'h0, calFreq});
            rd(`RPD_ADDR_FREQ);
            chk_val("freq reg", {16'h0, f[15:0]}, rdv);
        end
        // a write while the clock enable is low must not land
        @(posedge clk_sys);
        ce <= 1'b0;
        wr(`RPD_ADDR_FREQ, ~f);
        ce <= 1'b1;
        settle();
        chk_val("frozen calFreq", {16'h0, f[15:0]}, {16'h0, calFreq});
        $display("test frequency done");
        // mid-run reset returns to continuous mode with cleared report
        @(posedge clk_sys);
        nrst <= 1'b0;
        repeat (2) @(posedge clk_sys);
        nrst <= 1'b1;
        #1;
        chk_val("reset power", 32'h0, {16'h0, reportPower});
        rd(`RPD_ADDR_CTRL);
        chk_val("reset ctrl", 32'h0, rdv);
        for (int i = 0; i < WLEN; i++) win[i] = 16'($urandom);
        run_win(1'b1, peak());
        $display("test reset again done");
        end_sim();
    end
endmodule // rpd_power_report_bench
